// [dki_defines.svh]
// Offsets, field positions and timing counts of the diskette register block.
// Assumes it is included by bare name from the datapath, register and checker files.
`ifndef DKI_DEFINES_SVH
`define DKI_DEFINES_SVH
`define DKI_ADDR_W 10
`define DKI_OFS_STATUS_A 10'h3F0
`define DKI_OFS_STATUS_B 10'h3F1
`define DKI_OFS_OUTPUT_CTL 10'h3F2
`define DKI_OFS_MAIN_STATUS 10'h3F4
`define DKI_OFS_CMD_DATA 10'h3F5
`define DKI_OFS_SENSE_CONFIG 10'h3F7
`define DKI_OCR_RESET 8'h00
`define DKI_OCR_GATE_BIT 3
`define DKI_OCR_CTL_RST_N_BIT 2
`define DKI_CFG_NO_PRECOMP_BIT 2
`define DKI_CFG_RATE250_BIT 1
`define DKI_CFG_MASK 8'h06
`define DKI_CLK_MHZ 100
`define DKI_RATE500_KBPS 500
`define DKI_RATE250_KBPS 250
`define DKI_BIT_CYC_FAST ((`DKI_CLK_MHZ * 1000) / `DKI_RATE500_KBPS)
`define DKI_BIT_CYC_SLOW ((`DKI_CLK_MHZ * 1000) / `DKI_RATE250_KBPS)
`define DKI_PRECOMP_CYC 8'h03
`define DKI_RESULT_BYTES 3'h7
`define DKI_CMD_BYTES 4'h9
`define DKI_EXEC_CYC 16'h0100
`endif

// [dki_pkg.sv]
// Types shared by the diskette register block and its data path.
// Assumes dki_defines.svh is reachable on the include path.
package dki_pkg;
  typedef enum {PH_COMMAND, PH_EXECUTE, PH_RESULT} dki_phase_e;
  typedef struct packed {
    logic [3:0] motor_en;
    logic gate;
    logic ctl_rst_n;
    logic [1:0] drive_sel;
  } dki_ocr_s;
  typedef struct packed {
    logic no_precomp;
    logic rate_250;
  } dki_cfg_s;
endpackage

// [dki_datapath.sv]
// Write clock, precompensation and read clock oscillator with phase detector.
// Assumes read data arrives synchronous to CLOCK as a one-cycle pulse per flux edge.
`timescale 1ns/1ps
`default_nettype none
`include "dki_defines.svh"
module dki_datapath
  import dki_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire dki_cfg_s cfg,
  input wire logic wr_bit,
  input wire logic rd_pulse,
  output logic wr_clk,
  output logic wr_data,
  output logic rd_clk,
  output logic rd_data
);
  logic [15:0] wr_cnt_reg;
  logic [15:0] osc_cnt_reg;
  logic [15:0] period;
  logic [1:0] delay_reg;

  assign period = cfg.rate_250 ? 16'(`DKI_BIT_CYC_SLOW) : 16'(`DKI_BIT_CYC_FAST);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt_reg <= 16'h0000;
      wr_clk <= 1'b0;
    end else if (wr_cnt_reg >= period - 16'h0001) begin
      wr_cnt_reg <= 16'h0000;
      wr_clk <= 1'b1;
    end else begin
      wr_cnt_reg <= wr_cnt_reg + 16'h0001;
      wr_clk <= 1'b0;
    end
  end

  // Precompensation shifts the write pulse late by a few cycles unless disabled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_reg <= 2'h0;
      wr_data <= 1'b0;
    end else begin
      delay_reg <= {delay_reg[0], wr_clk & wr_bit};
      wr_data <= cfg.no_precomp ? (wr_clk & wr_bit) : delay_reg[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // An edge early in the window shortens the period, a late one stretches it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_reg <= 16'h0000;
      rd_clk <= 1'b0;
      rd_data <= 1'b0;
    end else begin
      rd_data <= rd_pulse;
      if (rd_pulse && osc_cnt_reg < (period >> 1)) begin
        osc_cnt_reg <= osc_cnt_reg + 16'h0002;
        rd_clk <= 1'b0;
      end else if (osc_cnt_reg >= period - 16'h0001) begin
        osc_cnt_reg <= rd_pulse ? 16'h0001 : 16'h0000;
        rd_clk <= 1'b1;
      end else begin
        osc_cnt_reg <= rd_pulse ? osc_cnt_reg : osc_cnt_reg + 16'h0001;
        rd_clk <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [dki_regs.sv]
// Host register block of the diskette subsystem: gate array ports and controller pair.
// Assumes a synchronous byte-wide port bus, one access per strobe cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dki_defines.svh"
// Functional notes
// - status port A reports request and drive lines.
// - status port B reports selects and latched data.
// - output control drives motors and controller reset.
// - reset clears the whole output control register.
// - output control bit 3 gates interrupt and DMA.
// - two-bit field selects one of four drives.
// - input sense reports change and configuration bits.
// - configuration write sets precompensation and rate.
// - configured rate and precompensation drive write path.
// - phase detector keeps read clock aligned.
// - main status reads have no side effects.
// - data port presents one stacked register.
// - status bit 7 means data port ready.
// - status bit 6 gives transfer direction.
// - status bit 5 shows non-DMA mode.
// - status bit 4 set during execution.
// - status bits 1 and 0 show seeking.
// - commands run command, execute, result phases.
// - port select line picks status or data.
module dki_regs
  import dki_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [`DKI_ADDR_W-1:0] ADDR,
  input wire logic RD_STB,
  input wire logic WR_STB,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic NON_DMA_MODE,
  input wire logic [1:0] SEEK_BUSY,
  input wire logic TRACK_ZERO,
  input wire logic INDEX,
  input wire logic WRITE_PROTECT,
  input wire logic DISKETTE_CHANGE,
  input wire logic RD_FLUX,
  output logic DISKETTE_INTERRUPT_LINE,
  output logic DISKETTE_DMA_REQUEST,
  output logic [3:0] MOTOR_EN,
  output logic [3:0] DRIVE_SEL_N,
  output logic CTL_RESET_N,
  output logic STEP,
  output logic DIRECTION_N,
  output logic HEAD1_SEL_N,
  output logic WRITE_ENABLE,
  output logic WRITE_DATA,
  output logic READ_DATA,
  output logic READ_CLOCK
);
  dki_ocr_s ocr_reg;
  dki_cfg_s cfg_reg;
  dki_phase_e phase_reg;
  logic [3:0] cmd_cnt_reg;
  logic [2:0] res_cnt_reg;
  logic [15:0] exec_cnt_reg;
  logic [7:0] cmd_stack_reg [0:8];
  logic irq_raw_reg;
  logic drq_raw_reg;
  logic step_latch_reg;
  logic wr_data_latch_reg;
  logic rd_data_latch_reg;
  logic wr_en_latch_reg;
  logic wr_clk;
  logic wr_data;
  logic rd_clk;
  logic rd_data;
  logic [7:0] main_status;
  logic [7:0] rdata_next;
  logic [3:0] sel_onehot;
  logic wr_ocr;
  logic wr_cfg;
  logic wr_cmd;
  logic rd_cmd;
  logic rd_port_a;
  logic rd_port_b;

  function automatic logic [3:0] drive_decode(input logic [1:0] sel);
    drive_decode = 4'h1 << sel;
  endfunction

  function automatic logic hit(input logic [`DKI_ADDR_W-1:0] a,
                               input logic [`DKI_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign sel_onehot = drive_decode(ocr_reg.drive_sel);

  // Strobe decodes shared by the sequencer, the stack and the read-clear latches.
  assign wr_ocr = WR_STB && hit(ADDR, `DKI_OFS_OUTPUT_CTL);
  assign wr_cfg = WR_STB && hit(ADDR, `DKI_OFS_SENSE_CONFIG);
  assign wr_cmd = WR_STB && hit(ADDR, `DKI_OFS_CMD_DATA);
  assign rd_cmd = RD_STB && hit(ADDR, `DKI_OFS_CMD_DATA);
  assign rd_port_a = RD_STB && hit(ADDR, `DKI_OFS_STATUS_A);
  assign rd_port_b = RD_STB && hit(ADDR, `DKI_OFS_STATUS_B);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ocr_reg <= dki_ocr_s'(`DKI_OCR_RESET);
    end else if (wr_ocr) begin
      ocr_reg <= dki_ocr_s'(WDATA);
    end
  end

  // Bits the host must write as zero are simply not stored.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_reg <= '0;
    end else if (wr_cfg) begin
      cfg_reg.no_precomp <= WDATA[`DKI_CFG_NO_PRECOMP_BIT];
      cfg_reg.rate_250 <= WDATA[`DKI_CFG_RATE250_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Controller sequencer. Held idle while the output control reset bit is low.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      phase_reg <= PH_COMMAND;
      cmd_cnt_reg <= 4'h0;
      res_cnt_reg <= 3'h0;
      exec_cnt_reg <= 16'h0000;
    end else if (!ocr_reg.ctl_rst_n) begin
      phase_reg <= PH_COMMAND;
      cmd_cnt_reg <= 4'h0;
      res_cnt_reg <= 3'h0;
      exec_cnt_reg <= 16'h0000;
    end else begin
      case (phase_reg)
        PH_COMMAND: begin
          if (wr_cmd) begin
            if (cmd_cnt_reg == `DKI_CMD_BYTES - 4'h1) begin
              cmd_cnt_reg <= 4'h0;
              exec_cnt_reg <= 16'h0000;
              phase_reg <= PH_EXECUTE;
            end else begin
              cmd_cnt_reg <= cmd_cnt_reg + 4'h1;
            end
          end
        end
        PH_EXECUTE: begin
          if (exec_cnt_reg == `DKI_EXEC_CYC - 16'h0001) begin
            res_cnt_reg <= 3'h0;
            phase_reg <= PH_RESULT;
          end else begin
            exec_cnt_reg <= exec_cnt_reg + 16'h0001;
          end
        end
        PH_RESULT: begin
          if (rd_cmd) begin
            if (res_cnt_reg == `DKI_RESULT_BYTES - 3'h1) begin
              phase_reg <= PH_COMMAND;
            end else begin
              res_cnt_reg <= res_cnt_reg + 3'h1;
            end
          end
        end
        default: phase_reg <= PH_COMMAND;
      endcase
    end
  end

  // Command bytes are kept; result bytes echo the first seven of them back in stack order.
  always_ff @(posedge CLOCK) begin
    if (phase_reg == PH_COMMAND && wr_cmd) begin
      cmd_stack_reg[cmd_cnt_reg] <= WDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt raised two cycles after result phase entry, DMA request two cycles into execution.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_raw_reg <= 1'b0;
      drq_raw_reg <= 1'b0;
      DISKETTE_INTERRUPT_LINE <= 1'b0;
      DISKETTE_DMA_REQUEST <= 1'b0;
    end else begin
      irq_raw_reg <= (phase_reg == PH_RESULT);
      drq_raw_reg <= (phase_reg == PH_EXECUTE) && !NON_DMA_MODE;
      DISKETTE_INTERRUPT_LINE <= irq_raw_reg & ocr_reg.gate;
      DISKETTE_DMA_REQUEST <= drq_raw_reg & ocr_reg.gate;
    end
  end

  // Drive control lines follow the output control register one cycle later.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      MOTOR_EN <= 4'h0;
      DRIVE_SEL_N <= 4'hF;
      CTL_RESET_N <= 1'b0;
    end else begin
      MOTOR_EN <= ocr_reg.motor_en;
      DRIVE_SEL_N <= ~sel_onehot;
      CTL_RESET_N <= ocr_reg.ctl_rst_n;
    end
  end

  // No seek logic of its own: steps pace on the write clock, outward, on head 0 only.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      STEP <= 1'b0;
      DIRECTION_N <= 1'b1;
      HEAD1_SEL_N <= 1'b1;
    end else begin
      STEP <= |SEEK_BUSY & wr_clk;
      DIRECTION_N <= 1'b1;
      HEAD1_SEL_N <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_ENABLE <= 1'b0;
      WRITE_DATA <= 1'b0;
      READ_DATA <= 1'b0;
      READ_CLOCK <= 1'b0;
    end else begin
      WRITE_ENABLE <= (phase_reg == PH_EXECUTE);
      WRITE_DATA <= wr_data;
      READ_DATA <= rd_data;
      READ_CLOCK <= rd_clk;
    end
  end

  // Latched lines hold a pulse until their status port is read; a new pulse wins.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      step_latch_reg <= 1'b0;
    end else begin
      step_latch_reg <= STEP | (step_latch_reg & !rd_port_a);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_data_latch_reg <= 1'b0;
      rd_data_latch_reg <= 1'b0;
      wr_en_latch_reg <= 1'b0;
    end else begin
      wr_data_latch_reg <= WRITE_DATA | (wr_data_latch_reg & !rd_port_b);
      rd_data_latch_reg <= READ_DATA | (rd_data_latch_reg & !rd_port_b);
      wr_en_latch_reg <= WRITE_ENABLE | (wr_en_latch_reg & !rd_port_b);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ready drops only while executing, so a held controller still reads as ready.
  always_comb begin
    main_status = 8'h00;
    main_status[7] = (phase_reg != PH_EXECUTE);
    main_status[6] = (phase_reg == PH_RESULT);
    main_status[5] = NON_DMA_MODE;
    main_status[4] = (phase_reg == PH_EXECUTE);
    main_status[1:0] = SEEK_BUSY;
  end

  always_comb begin
    rdata_next = 8'h00;
    case (ADDR)
      `DKI_OFS_STATUS_A: rdata_next = {DISKETTE_INTERRUPT_LINE, DISKETTE_DMA_REQUEST,
        step_latch_reg, TRACK_ZERO, HEAD1_SEL_N, INDEX, WRITE_PROTECT, DIRECTION_N};
      `DKI_OFS_STATUS_B: rdata_next = {1'b0, DRIVE_SEL_N[1], DRIVE_SEL_N[0],
        wr_data_latch_reg, rd_data_latch_reg, wr_en_latch_reg,
        DRIVE_SEL_N[3], DRIVE_SEL_N[2]};
      `DKI_OFS_MAIN_STATUS: rdata_next = main_status;
      `DKI_OFS_CMD_DATA: rdata_next = (phase_reg == PH_RESULT) ?
        cmd_stack_reg[4'(res_cnt_reg)] : 8'h00;
      `DKI_OFS_SENSE_CONFIG: rdata_next = {~DISKETTE_CHANGE, 3'h0, ocr_reg.gate,
        cfg_reg.no_precomp, cfg_reg.rate_250, 1'b0};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is held between strobes so a slow host still sees a stable byte.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (RD_STB) begin
      RDATA <= rdata_next;
    end
  end

  dki_datapath u_datapath (
    .clk(CLOCK),
    .rst_n(RST_N),
    .cfg(cfg_reg),
    .wr_bit(phase_reg == PH_EXECUTE),
    .rd_pulse(RD_FLUX),
    .wr_clk(wr_clk),
    .wr_data(wr_data),
    .rd_clk(rd_clk),
    .rd_data(rd_data)
  );
endmodule
`default_nettype wire

// [dki_drive_model.sv]
// Behavioural model of the attached diskette drives.
// Assumes step and select lines come from dki_regs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dki_drive_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] motor_en,
  input wire logic [3:0] drive_sel_n,
  input wire logic step,
  input wire logic direction_n,
  output logic track_zero,
  output logic index,
  output logic write_protect,
  output logic diskette_change,
  output logic rd_flux
);
  logic [6:0] cyl_reg;
  logic [5:0] rev_reg;
  logic step_q;
  logic spin;
  assign spin = |(motor_en & ~drive_sel_n);
  assign track_zero = (cyl_reg == 7'h00);
  assign write_protect = 1'b1;
  // The change line stays up until the first step pulse, even if the head stays at cylinder 0.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyl_reg <= 7'h00;
      step_q <= 1'b0;
      diskette_change <= 1'b1;
    end else begin
      step_q <= step;
      if (step && !step_q) begin
        diskette_change <= 1'b0;
        if (!direction_n) cyl_reg <= cyl_reg + 7'h01;
        else if (cyl_reg != 7'h00) cyl_reg <= cyl_reg - 7'h01;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rev_reg <= 6'h00;
    else if (spin) rev_reg <= rev_reg + 6'h01;
  end
  assign index = spin && (rev_reg == 6'h3F);
  assign rd_flux = spin && (rev_reg[1:0] == 2'h3);
endmodule
`default_nettype wire

// [dki_regs_chk.sv]
// Port-level checker for the diskette register block.
// Assumes it is bound to dki_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dki_defines.svh"
module dki_regs_chk (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [`DKI_ADDR_W-1:0] ADDR,
  input wire logic RD_STB,
  input wire logic WR_STB,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic NON_DMA_MODE,
  input wire logic [1:0] SEEK_BUSY,
  input wire logic TRACK_ZERO,
  input wire logic INDEX,
  input wire logic WRITE_PROTECT,
  input wire logic DISKETTE_CHANGE,
  input wire logic DISKETTE_INTERRUPT_LINE,
  input wire logic DISKETTE_DMA_REQUEST,
  input wire logic [3:0] MOTOR_EN,
  input wire logic [3:0] DRIVE_SEL_N,
  input wire logic CTL_RESET_N,
  input wire logic DIRECTION_N,
  input wire logic HEAD1_SEL_N,
  input wire logic RD_FLUX,
  input wire logic READ_DATA,
  input wire logic READ_CLOCK
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [7:0] ocr_q;
  logic [1:0] age;
  // Outputs are only compared once a write has had time to pass both register stages.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ocr_q <= 8'h00;
      age <= 2'h2;
    end else if (WR_STB && ADDR == `DKI_OFS_OUTPUT_CTL) begin
      ocr_q <= WDATA;
      age <= 2'h0;
    end else if (age != 2'h3) age <= age + 2'h1;
  end
  property p_rst_clear; $rose(RST_N) |-> MOTOR_EN == 4'h0 && !CTL_RESET_N; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
  property p_ocr_out; age == 2'h3 |-> MOTOR_EN == ocr_q[7:4] && CTL_RESET_N == ocr_q[2];
  endproperty
  a_ocr_out: assert property (p_ocr_out) else $error("motor or reset output wrong");
  property p_sel; age == 2'h3 |-> DRIVE_SEL_N == ~(4'h1 << ocr_q[1:0]); endproperty
  a_sel: assert property (p_sel) else $error("drive select wrong");
  property p_gate; age == 2'h3 && !ocr_q[3] |-> !DISKETTE_INTERRUPT_LINE[*2] and
    !DISKETTE_DMA_REQUEST; endproperty
  a_gate: assert property (p_gate) else $error("request not gated");
  property p_nodma; NON_DMA_MODE && $past(NON_DMA_MODE) && $past(NON_DMA_MODE, 2) |->
    !DISKETTE_DMA_REQUEST; endproperty
  a_nodma: assert property (p_nodma) else $error("DMA request in non-DMA mode");
  property p_port_a; RD_STB && ADDR == `DKI_OFS_STATUS_A |=> RDATA[7:6] ==
    {$past(DISKETTE_INTERRUPT_LINE), $past(DISKETTE_DMA_REQUEST)} && RDATA[4:0] ==
    {$past(TRACK_ZERO), $past(HEAD1_SEL_N), $past(INDEX), $past(WRITE_PROTECT),
    $past(DIRECTION_N)}; endproperty
  a_port_a: assert property (p_port_a) else $error("status port A wrong");
  property p_port_b; RD_STB && ADDR == `DKI_OFS_STATUS_B |=> !RDATA[7] &&
    RDATA[6:5] == $past(DRIVE_SEL_N[1:0]) && RDATA[1:0] == $past(DRIVE_SEL_N[3:2]);
  endproperty
  a_port_b: assert property (p_port_b) else $error("status port B wrong");
  property p_main; RD_STB && ADDR == `DKI_OFS_MAIN_STATUS |=>
    RDATA[5] == $past(NON_DMA_MODE) && RDATA[3:0] == {2'h0, $past(SEEK_BUSY)}; endproperty
  a_main: assert property (p_main) else $error("main status wrong");
  property p_sense; RD_STB && ADDR == `DKI_OFS_SENSE_CONFIG |=>
    RDATA[7] != $past(DISKETTE_CHANGE) && RDATA[6:4] == 3'h0 && !RDATA[0]; endproperty
  a_sense: assert property (p_sense) else $error("input sense wrong");
  property p_rclk_pulse; READ_CLOCK |=> !READ_CLOCK; endproperty
  a_rclk_pulse: assert property (p_rclk_pulse) else $error("read clock pulse too long");
  property p_rd_data; READ_DATA |-> $past(RD_FLUX, 2); endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not from flux input");
endmodule
bind dki_regs dki_regs_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
  .RD_STB(RD_STB), .WR_STB(WR_STB), .WDATA(WDATA), .RDATA(RDATA),
  .NON_DMA_MODE(NON_DMA_MODE), .SEEK_BUSY(SEEK_BUSY), .TRACK_ZERO(TRACK_ZERO),
  .INDEX(INDEX), .WRITE_PROTECT(WRITE_PROTECT), .DISKETTE_CHANGE(DISKETTE_CHANGE),
  .DISKETTE_INTERRUPT_LINE(DISKETTE_INTERRUPT_LINE),
  .DISKETTE_DMA_REQUEST(DISKETTE_DMA_REQUEST), .MOTOR_EN(MOTOR_EN),
  .DRIVE_SEL_N(DRIVE_SEL_N), .CTL_RESET_N(CTL_RESET_N), .DIRECTION_N(DIRECTION_N),
  .HEAD1_SEL_N(HEAD1_SEL_N), .RD_FLUX(RD_FLUX), .READ_DATA(READ_DATA),
  .READ_CLOCK(READ_CLOCK));
`default_nettype wire

// [diskette_interface_regs_test.sv]
// Self-checking bench for the diskette register block with a drive model.
// Assumes the checker is bound from dki_regs_chk.sv.
`timescale 1ns/1ps
`default_nettype none
module diskette_interface_regs_test;
  import dki_pkg::*;
  typedef struct packed {
    logic [7:0] ocr;
    logic [3:0] motor;
    logic [3:0] sel_n;
    logic sense3;
  } dki_row_s;
  logic CLOCK = 0, RST_N = 0, RD_STB = 0, WR_STB = 0, NON_DMA_MODE = 1;
  logic [9:0] ADDR = 10'h3F0;
  logic [7:0] WDATA = 8'h00, RDATA, d;
  logic [1:0] SEEK_BUSY = 2'h2;
  logic TRACK_ZERO, INDEX, WRITE_PROTECT, DISKETTE_CHANGE, RD_FLUX, irq, drq, CTL_RESET_N;
  logic STEP, DIRECTION_N, HEAD1_SEL_N, WRITE_ENABLE, WRITE_DATA, READ_DATA, READ_CLOCK;
  logic [3:0] MOTOR_EN, DRIVE_SEL_N;
  int n_errors = 0, checks = 0, i, n;
  dki_row_s rows [0:4] = '{'{8'h1C, 4'h1, 4'hE, 1'b1}, '{8'h2D, 4'h2, 4'hD, 1'b1},
    '{8'h4E, 4'h4, 4'hB, 1'b1}, '{8'h8F, 4'h8, 4'h7, 1'b1}, '{8'h04, 4'h0, 4'hE, 1'b0}};
  always #5 CLOCK = ~CLOCK;
  dki_regs dut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .RD_STB(RD_STB),
    .WR_STB(WR_STB), .WDATA(WDATA), .RDATA(RDATA), .NON_DMA_MODE(NON_DMA_MODE),
    .SEEK_BUSY(SEEK_BUSY), .TRACK_ZERO(TRACK_ZERO), .INDEX(INDEX),
    .WRITE_PROTECT(WRITE_PROTECT), .DISKETTE_CHANGE(DISKETTE_CHANGE), .RD_FLUX(RD_FLUX),
    .DISKETTE_INTERRUPT_LINE(irq), .DISKETTE_DMA_REQUEST(drq), .MOTOR_EN(MOTOR_EN),
    .DRIVE_SEL_N(DRIVE_SEL_N), .CTL_RESET_N(CTL_RESET_N), .STEP(STEP),
    .DIRECTION_N(DIRECTION_N), .HEAD1_SEL_N(HEAD1_SEL_N), .WRITE_ENABLE(WRITE_ENABLE),
    .WRITE_DATA(WRITE_DATA), .READ_DATA(READ_DATA), .READ_CLOCK(READ_CLOCK));
  dki_drive_model u_drv (.clk(CLOCK), .rst_n(RST_N), .motor_en(MOTOR_EN),
    .drive_sel_n(DRIVE_SEL_N), .step(STEP), .direction_n(DIRECTION_N),
    .track_zero(TRACK_ZERO), .index(INDEX), .write_protect(WRITE_PROTECT),
    .diskette_change(DISKETTE_CHANGE), .rd_flux(RD_FLUX));
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= v;
    WR_STB <= 1'b1;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
  endtask
  // Read data is registered, so it is taken just after the edge that samples the strobe.
  task rd(input logic [9:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    #1 d = RDATA;
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    conclude;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge CLOCK);
    RST_N <= 1'b1;
    foreach (rows[k]) begin
      wr(10'h3F2, rows[k].ocr);
      repeat (2) @(posedge CLOCK);
      #1 chk("motor", {4'h0, rows[k].motor}, {4'h0, MOTOR_EN});
      chk("select", {4'h0, rows[k].sel_n}, {4'h0, DRIVE_SEL_N});
      rd(10'h3F7);
      chk("sense_dma", {7'h0, rows[k].sense3}, {7'h0, d[3]});
      rd(10'h3F0);
      rd(10'h3F1);
    end
    rd(10'h3F3);
    chk("unmapped", 8'h00, d);
    wr(10'h3F7, 8'hFF);
    rd(10'h3F7);
    chk("config", 8'h06, d & 8'h7F);
    wr(10'h3F7, 8'h00);
    wr(10'h3F2, 8'h1C);
    NON_DMA_MODE <= 1'b0;
    rd(10'h3F4);
    chk("idle", 8'h82, d);
    for (i = 0; i < 9; i++) wr(10'h3F5, 8'hA0 + i[7:0]);
    rd(10'h3F4);
    chk("exec", 8'h12, d);
    chk("dma", 8'h01, {7'h0, drq});
    rd(10'h3F5);
    chk("early", 8'h00, d);
    wr(10'h3F2, 8'h14);
    repeat (3) @(posedge CLOCK);
    #1 chk("dma_gated", 8'h00, {7'h0, drq});
    wr(10'h3F2, 8'h1C);
    NON_DMA_MODE <= 1'b1;
    rd(10'h3F4);
    chk("non_dma", 8'h32, d);
    repeat (2) @(posedge CLOCK);
    #1 chk("dma_off", 8'h00, {7'h0, drq});
    @(posedge CLOCK);
    NON_DMA_MODE <= 1'b0;
    for (n = 0; n < 400 && d[7] !== 1'b1; n++) rd(10'h3F4);
    chk("result_dir", 8'hC0, d & 8'hC0);
    repeat (3) @(posedge CLOCK);
    #1 chk("irq", 8'h01, {7'h0, irq});
    wr(10'h3F2, 8'h14);
    repeat (3) @(posedge CLOCK);
    #1 chk("irq_gated", 8'h00, {7'h0, irq});
    wr(10'h3F2, 8'h1C);
    for (i = 0; i < 7; i++) begin
      rd(10'h3F5);
      chk("result", 8'hA0 + i[7:0], d);
    end
    rd(10'h3F0);
    chk("step_latch", 8'h20, d & 8'h20);
    rd(10'h3F1);
    chk("latched_b", 8'h1C, d & 8'h1C);
    rd(10'h3F4);
    chk("back", 8'h82, d & 8'hF3);
    for (n = 0; n < 450 && READ_CLOCK !== 1'b1; n++) @(negedge CLOCK);
    chk("read_clock", 8'h01, {7'h0, READ_CLOCK});
    @(posedge CLOCK);
    RST_N <= 1'b0;
    #1 chk("rst_motor", 8'h00, {4'h0, MOTOR_EN});
    chk("rst_ctl", 8'h00, {7'h0, CTL_RESET_N});
    @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    conclude;
  end
endmodule
`default_nettype wire
